// >>> logic/ptcd_pkg.sv
// constants and types for the pci target configuration decode block
package ptcd_pkg;

  // ****************************************************************
  // bus commands
  // ****************************************************************
  localparam logic [3:0] CMD_IO_RD   = 4'h2;
  localparam logic [3:0] CMD_IO_WR   = 4'h3;
  localparam logic [3:0] CMD_MEM_RD  = 4'h6;
  localparam logic [3:0] CMD_MEM_WR  = 4'h7;
  localparam logic [3:0] CMD_CFG_RD  = 4'ha;
  localparam logic [3:0] CMD_CFG_WR  = 4'hb;
  localparam logic [3:0] CMD_MEM_RDM = 4'hc;
  localparam logic [3:0] CMD_MEM_RDL = 4'he;
  localparam logic [3:0] CMD_MEM_WRI = 4'hf;

  // ****************************************************************
  // configuration space layout
  // ****************************************************************
  localparam int          IDX_W      = 6;
  localparam int          CFG_WORDS  = 64;
  localparam int          ROM_OFF_W  = 20;
  localparam int          WIN_OFF_W  = 5;
  localparam logic [5:0]  IDX_ID     = 6'h00;
  localparam logic [5:0]  IDX_CMD    = 6'h01;
  localparam logic [5:0]  IDX_CLASS  = 6'h02;
  localparam logic [5:0]  IDX_MISC   = 6'h03;
  localparam logic [5:0]  IDX_BAR0   = 6'h04;
  localparam logic [5:0]  IDX_BAR1   = 6'h05;
  localparam logic [5:0]  IDX_ROM    = 6'h0c;
  localparam logic [5:0]  IDX_INTR   = 6'h0f;
  localparam int          IOEN_BIT   = 0;
  localparam int          MEMEN_BIT  = 1;
  localparam int          ROMEN_BIT  = 0;
  localparam int          FBB_AD_BIT = 23;
  localparam logic [15:0] CMD_WMASK  = 16'h0003;
  localparam logic [15:0] STATUS_FIX = 16'h0080;
  localparam logic [31:0] WIN_MASK   = 32'hffff_ffe0;
  localparam logic [31:0] ROM_MASK   = 32'hfff0_0000;
  localparam logic [31:0] ROMEN_MASK = 32'h0000_0001;
  localparam logic [31:0] BAR0_FLAGS = 32'h0000_0001;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {S_IDLE, S_WAIT, S_DEV, S_XFER, S_STOP, S_TURN} ptcd_state_e;

  // cycle context caught in the address phase
  typedef struct packed {
    logic                 cfg;
    logic                 rom;
    logic                 write;
    logic                 retry;
    logic [IDX_W-1:0]     idx;
    logic [ROM_OFF_W-1:0] off;
  } ptcd_cyc_s;

  // request to the register groups and rom behind this port
  typedef struct packed {
    logic                 valid;
    logic                 write;
    logic                 rom;
    logic [ROM_OFF_W-1:0] off;
    logic [3:0]           be;
    logic [31:0]          wdata;
  } ptcd_res_s;

endpackage

// >>> logic/ptcd_cfg_mem.sv
// byte-lane configuration word store with registered read
`timescale 1ns/1ns
module ptcd_cfg_mem
  import ptcd_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic [3:0]       wr_be,
  input  wire logic [31:0]      wr_data,
  input  wire logic [IDX_W-1:0] rd_idx,
  output logic      [31:0]      rd_data
);

  // one storage array per byte lane
  for (genvar g = 0; g < 4; g++) begin : g_lane
    logic [7:0] lane_mem [CFG_WORDS];
    always_ff @(posedge clk) begin
      if (rst) begin
        for (int w = 0; w < CFG_WORDS; w++) begin
          lane_mem[w] <= 8'h00;
        end
        rd_data[8*g +: 8] <= 8'h00;
      end else begin
        if (wr_en && wr_be[g]) begin
          lane_mem[wr_idx] <= wr_data[8*g +: 8];
        end
        rd_data[8*g +: 8] <= lane_mem[rd_idx];
      end
    end
  end

endmodule

// >>> logic/ptcd_target.sv
// pci target: command decode, configuration space and slave cycle timing
`timescale 1ns/1ns
module ptcd_target
  import ptcd_pkg::*;
#(
  parameter logic [31:0] ID_WORD    = 32'h00a5_0f0f, // arbitrary value
  parameter logic [31:0] CLASS_WORD = 32'h0000_0000
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        frame_n,
  input  wire logic        irdy_n,
  input  wire logic        idsel,
  input  wire logic [3:0]  cbe_n,
  input  wire logic [31:0] ad_in,
  output logic      [31:0] ad_out,
  output logic             ad_oe_n,
  output logic             devsel_n,
  output logic             trdy_n,
  output logic             stop_n,
  output logic             ctl_oe_n,
  input  wire logic        eeprom_load_busy,
  output ptcd_res_s        res_req,
  input  wire logic [31:0] res_rdata
);

  // ****************************************************************
  // state and registers
  // ****************************************************************
  ptcd_state_e  st_reg;
  ptcd_state_e  st_next;
  ptcd_cyc_s    cyc_reg;
  ptcd_res_s    res_req_reg;
  logic         frame_q_reg;
  logic [15:0]  cmd_reg;
  logic [31:0]  bar0_reg;
  logic [31:0]  bar1_reg;
  logic [31:0]  rom_reg;
  logic [31:0]  ad_out_reg;
  logic         ad_oe_n_reg;
  logic         devsel_n_reg;
  logic         trdy_n_reg;
  logic         stop_n_reg;
  logic         ctl_oe_n_reg;
  logic [31:0]  mem_rdata;
  logic [31:0]  cfg_rdata;
  logic [31:0]  wmerged;
  logic [3:0]   be;
  logic         addr_ph;
  logic         accept;
  logic         cfg_hit;
  logic         io_hit;
  logic         mem_hit;
  logic         rom_hit;
  logic         mem_rd;
  logic         mem_wr;
  logic         claim;
  logic         go;
  logic         xfer;
  logic         cfg_wr;
  logic         is_write;

  assign ad_out   = ad_out_reg;
  assign ad_oe_n  = ad_oe_n_reg;
  assign devsel_n = devsel_n_reg;
  assign trdy_n   = trdy_n_reg;
  assign stop_n   = stop_n_reg;
  assign ctl_oe_n = ctl_oe_n_reg;
  assign res_req  = res_req_reg;

  // implemented configuration words
  function automatic logic cfg_impl(input logic [IDX_W-1:0] idx);
    cfg_impl = (idx == IDX_ID) || (idx == IDX_CMD) || (idx == IDX_CLASS) ||
               (idx == IDX_MISC) || (idx == IDX_BAR0) || (idx == IDX_BAR1) ||
               (idx == IDX_ROM) || (idx == IDX_INTR);
  endfunction

  // ****************************************************************
  // address phase decode
  // ****************************************************************

  // previous frame level marks the first clock of an address phase
  always_ff @(posedge clk) begin
    if (rst) begin
      frame_q_reg <= 1'b1;
    end else begin
      frame_q_reg <= frame_n;
    end
  end

  // a new address phase follows idle or another target's last data phase
  assign addr_ph = !frame_n && frame_q_reg;
  assign accept  = (st_reg == S_IDLE) || (st_reg == S_TURN);

  // command and window matching
  always_comb begin
    cfg_hit = idsel && (ad_in[1:0] == 2'b00) &&
              ((cbe_n == CMD_CFG_RD) || (cbe_n == CMD_CFG_WR));
    mem_rd  = (cbe_n == CMD_MEM_RD) || (cbe_n == CMD_MEM_RDM) ||
              (cbe_n == CMD_MEM_RDL);
    mem_wr  = (cbe_n == CMD_MEM_WR) || (cbe_n == CMD_MEM_WRI);
    io_hit  = cmd_reg[IOEN_BIT] && ((cbe_n == CMD_IO_RD) || (cbe_n == CMD_IO_WR)) &&
              ((ad_in & WIN_MASK) == (bar0_reg & WIN_MASK));
    mem_hit = cmd_reg[MEMEN_BIT] && (mem_rd || mem_wr) &&
              ((ad_in & WIN_MASK) == (bar1_reg & WIN_MASK));
    rom_hit = cmd_reg[MEMEN_BIT] && rom_reg[ROMEN_BIT] && (mem_rd || mem_wr) &&
              ((ad_in & ROM_MASK) == (rom_reg & ROM_MASK));
    // other command codes fall through unclaimed
    claim    = cfg_hit || io_hit || mem_hit || rom_hit;
    is_write = (cbe_n == CMD_CFG_WR) || (cbe_n == CMD_IO_WR) || mem_wr;
  end

  assign go   = addr_ph && accept && claim;
  assign xfer = (st_reg == S_XFER) && !irdy_n;
  assign be   = ~cbe_n;

  // cycle context captured once per claim
  always_ff @(posedge clk) begin
    if (rst) begin
      cyc_reg <= '0;
    end else if (go) begin
      cyc_reg.cfg   <= cfg_hit;
      cyc_reg.rom   <= !cfg_hit && !io_hit && !mem_hit;
      cyc_reg.write <= is_write;
      cyc_reg.retry <= eeprom_load_busy;
      cyc_reg.idx   <= ad_in[7:2];
      cyc_reg.off   <= (cfg_hit || io_hit || mem_hit) ?
                       {{(ROM_OFF_W-WIN_OFF_W){1'b0}}, ad_in[WIN_OFF_W-1:0]} :
                       ad_in[ROM_OFF_W-1:0];
    end
  end

  // ****************************************************************
  // cycle sequencer
  // ****************************************************************

  // next state of the slave cycle
  always_comb begin
    case (st_reg)
      S_IDLE, S_TURN: begin
        st_next = go ? S_WAIT : S_IDLE;
      end
      S_WAIT: begin
        st_next = cyc_reg.retry ? S_STOP : S_DEV;
      end
      S_DEV: begin
        st_next = S_XFER;
      end
      S_XFER: begin
        if (!irdy_n) begin
          st_next = frame_n ? S_TURN : S_STOP;
        end else begin
          st_next = S_XFER;
        end
      end
      S_STOP: begin
        st_next = frame_n ? S_TURN : S_STOP;
      end
      default: begin
        st_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= S_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // target control lines, driven from the clock after medium decode
  always_ff @(posedge clk) begin
    if (rst) begin
      devsel_n_reg <= 1'b1;
      trdy_n_reg   <= 1'b1;
      stop_n_reg   <= 1'b1;
      ctl_oe_n_reg <= 1'b1;
    end else begin
      devsel_n_reg <= !((st_next == S_DEV) || (st_next == S_XFER) ||
                        (st_next == S_STOP));
      trdy_n_reg   <= !(st_next == S_XFER);
      stop_n_reg   <= !((st_next == S_STOP) ||
                        ((st_next == S_XFER) && (st_reg == S_DEV) && !frame_n && !irdy_n) ||
                        ((st_next == S_XFER) && (st_reg == S_XFER) && !stop_n_reg));
      // one cycle of driven high before release avoids contention
      ctl_oe_n_reg <= (st_next == S_IDLE) || (st_next == S_WAIT);
    end
  end

  // ****************************************************************
  // data path
  // ****************************************************************

  // configuration read mux
  always_comb begin
    case (cyc_reg.idx)
      IDX_ID:    cfg_rdata = ID_WORD;
      IDX_CMD:   cfg_rdata = {STATUS_FIX, cmd_reg};
      IDX_CLASS: cfg_rdata = CLASS_WORD;
      IDX_BAR0:  cfg_rdata = bar0_reg | BAR0_FLAGS;
      IDX_BAR1:  cfg_rdata = bar1_reg;
      IDX_ROM:   cfg_rdata = rom_reg;
      IDX_MISC:  cfg_rdata = mem_rdata;
      IDX_INTR:  cfg_rdata = mem_rdata;
      default:   cfg_rdata = 32'h0000_0000;
    endcase
  end

  // byte-lane merge of write data over the current word
  for (genvar g = 0; g < 4; g++) begin : g_merge
    assign wmerged[8*g +: 8] = be[g] ? ad_in[8*g +: 8] : cfg_rdata[8*g +: 8];
  end

  // read data and bus drive
  always_ff @(posedge clk) begin
    if (rst) begin
      ad_out_reg  <= 32'h0000_0000;
      ad_oe_n_reg <= 1'b1;
    end else begin
      if ((st_reg == S_DEV) && !cyc_reg.write) begin
        ad_out_reg <= cyc_reg.cfg ? cfg_rdata : res_rdata;
      end
      ad_oe_n_reg <= !(((st_next == S_DEV) || (st_next == S_XFER)) &&
                       !cyc_reg.write && !cyc_reg.retry);
    end
  end

  assign cfg_wr = xfer && cyc_reg.cfg && cyc_reg.write;

  // configuration registers that steer decode
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_reg  <= 16'h0000;
      bar0_reg <= 32'h0000_0000;
      bar1_reg <= 32'h0000_0000;
      rom_reg  <= 32'h0000_0000;
    end else if (cfg_wr) begin
      case (cyc_reg.idx)
        IDX_CMD:  cmd_reg  <= wmerged[15:0] & CMD_WMASK;
        IDX_BAR0: bar0_reg <= wmerged & WIN_MASK;
        IDX_BAR1: bar1_reg <= wmerged & WIN_MASK;
        IDX_ROM:  rom_reg  <= wmerged & (ROM_MASK | ROMEN_MASK);
        default:  cmd_reg  <= cmd_reg;
      endcase
    end
  end

  // scratch configuration words
  ptcd_cfg_mem u_mem (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (cfg_wr && ((cyc_reg.idx == IDX_MISC) || (cyc_reg.idx == IDX_INTR))),
    .wr_idx  (cyc_reg.idx),
    .wr_be   (be),
    .wr_data (ad_in),
    .rd_idx  (cyc_reg.idx),
    .rd_data (mem_rdata)
  );

  // requests to register groups and rom; rom writes complete with no effect
  always_ff @(posedge clk) begin
    if (rst) begin
      res_req_reg <= '0;
    end else begin
      res_req_reg.valid <= 1'b0;
      if ((st_reg == S_WAIT) && !cyc_reg.cfg && !cyc_reg.retry && !cyc_reg.write) begin
        res_req_reg.valid <= 1'b1;
        res_req_reg.write <= 1'b0;
        res_req_reg.rom   <= cyc_reg.rom;
        res_req_reg.off   <= cyc_reg.off;
        res_req_reg.be    <= be;
        res_req_reg.wdata <= 32'h0000_0000;
      end else if (xfer && !cyc_reg.cfg && cyc_reg.write && !cyc_reg.rom) begin
        res_req_reg.valid <= 1'b1;
        res_req_reg.write <= 1'b1;
        res_req_reg.rom   <= 1'b0;
        res_req_reg.off   <= cyc_reg.off;
        res_req_reg.be    <= be;
        res_req_reg.wdata <= ad_in;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_cfg_claim: assert property (go && cfg_hit |-> ##2 !devsel_n_reg)
    else $error("config cycle not claimed");
  a_medium_decode: assert property (go |=> devsel_n_reg ##1 !devsel_n_reg)
    else $error("devsel not at medium timing");
  a_trdy_third: assert property (go && !eeprom_load_busy |-> ##2 trdy_n_reg ##1 !trdy_n_reg)
    else $error("trdy not on third data clock");
  a_retry_resp: assert property (go && eeprom_load_busy
      |-> ##2 (!devsel_n_reg && !stop_n_reg && trdy_n_reg))
    else $error("retry response wrong");
  a_retry_hold: assert property ((st_reg == S_STOP) && !frame_n |=> !stop_n_reg)
    else $error("stop released before frame");
  a_burst_stop: assert property ((st_reg == S_DEV) && !frame_n && !irdy_n
      |=> (!trdy_n_reg && !stop_n_reg))
    else $error("burst not stopped with trdy");
  a_second_phase: assert property (xfer && !frame_n |=> (trdy_n_reg && !stop_n_reg))
    else $error("second data phase accepted");
  a_no_claim: assert property (addr_ph && accept && !claim |-> ##2 devsel_n_reg)
    else $error("unsupported command claimed");
  a_b2b_claim: assert property (addr_ph && accept && claim &&
      (!$past(irdy_n) || (st_reg == S_TURN)) |-> ##2 !devsel_n_reg)
    else $error("back-to-back cycle missed");
  a_fbb_const: assert property ((st_reg == S_XFER) && cyc_reg.cfg && !cyc_reg.write &&
      (cyc_reg.idx == IDX_CMD) |-> ad_out_reg[FBB_AD_BIT])
    else $error("fast back-to-back bit not one");
  a_unimpl_zero: assert property ((st_reg == S_XFER) && cyc_reg.cfg && !cyc_reg.write &&
      !cfg_impl(cyc_reg.idx) |-> (ad_out_reg == 32'h0000_0000))
    else $error("unimplemented word not zero");
  a_bar_align: assert property (cfg_wr && (cyc_reg.idx == IDX_BAR0)
      |=> (bar0_reg[WIN_OFF_W-1:0] == 5'h00))
    else $error("window base not aligned");

  c_cfg_read: cover property (go && cfg_hit && !is_write ##3 !trdy_n_reg);
  c_retry: cover property (go && eeprom_load_busy ##2 !stop_n_reg);
  c_burst: cover property ((st_reg == S_DEV) && !frame_n && !irdy_n);
  c_b2b: cover property (addr_ph && accept && claim && !$past(irdy_n));

endmodule

// >>> verif/ptcd_host_model.sv
// pci initiator model driving address and data phases toward the target
`timescale 1ns/1ns
module ptcd_host_model
  import ptcd_pkg::*;
(
  input  wire logic        clk,
  output logic             frame_n,
  output logic             irdy_n,
  output logic             idsel,
  output logic      [3:0]  cbe_n,
  output logic      [31:0] ad_in,
  input  wire logic [31:0] ad_out,
  input  wire logic        ad_oe_n,
  input  wire logic        devsel_n,
  input  wire logic        trdy_n,
  input  wire logic        stop_n,
  input  wire logic        ctl_oe_n
);
  logic [31:0] ad_drv = 32'h0;
  logic        ad_en  = 1'h0;
  logic [31:0] ad_last = 32'h0;

  // bus level: target, host, or a changing pattern when nobody drives
  assign ad_in = !ad_oe_n ? ad_out : (ad_en ? ad_drv : ~ad_last);

  // last bus value, so a floating bus never repeats it
  always @(posedge clk) begin
    ad_last <= ad_in;
  end

  // idle bus at time zero
  initial begin
    frame_n = 1'h1;
    irdy_n  = 1'h1;
    idsel   = 1'h0;
    cbe_n   = 4'hf;
  end

  // one transaction; edges are counted from the address edge
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input logic sel,
                      input logic [3:0] be, input logic [31:0] wd, input logic burst,
                      input int wt, input logic fbb, output logic [31:0] rd,
                      output int dev_at, output int trdy_at, output int stop_at);
    int   k;
    logic done;
    dev_at = 0;
    trdy_at = 0;
    stop_at = 0;
    rd = 32'h0;
    done = 1'h0;
    k = 0;
    if (fbb) begin
      // foreign one-phase cycle with no idle edge before ours
      @(negedge clk);
      frame_n = 1'h0;
      cbe_n = CMD_MEM_RD;
      ad_drv = 32'h4000_0000;
      ad_en = 1'h1;
      @(negedge clk);
      frame_n = 1'h1;
      irdy_n = 1'h0;
      ad_en = 1'h0;
    end
    @(negedge clk);
    frame_n = 1'h0;
    irdy_n = 1'h1;
    idsel = sel;
    cbe_n = cmd;
    ad_drv = addr;
    ad_en = 1'h1;
    @(negedge clk);
    idsel = 1'h0;
    cbe_n = ~be;
    ad_drv = wd;
    ad_en = cmd[0];
    irdy_n = (wt == 0) ? 1'h0 : 1'h1;
    frame_n = (burst || wt != 0) ? 1'h0 : 1'h1;
    while (!done && k < 12) begin
      @(posedge clk);
      k++;
      if (!ctl_oe_n && !devsel_n && dev_at == 0) dev_at = k;
      if (!ctl_oe_n && !trdy_n && trdy_at == 0) trdy_at = k;
      if (!ctl_oe_n && !stop_n && stop_at == 0) stop_at = k;
      if (!irdy_n && !ctl_oe_n && (!trdy_n || !stop_n)) begin
        done = 1'h1;
        if (!trdy_n) rd = ad_in;
      end else if (k == 5 && dev_at == 0) begin
        done = 1'h1;
      end
      @(negedge clk);
      if (!done && k >= wt) begin
        irdy_n = 1'h0;
        frame_n = burst ? 1'h0 : 1'h1;
      end
    end
    // burst or stop: drop frame, keep irdy for the last phase
    if (!frame_n) begin
      frame_n = 1'h1;
      irdy_n = 1'h0;
      @(posedge clk);
      if (!ctl_oe_n && !stop_n && stop_at == 0) stop_at = k + 1;
      @(negedge clk);
    end
    irdy_n = 1'h1;
    ad_en = 1'h0;
    cbe_n = 4'hf;
    @(negedge clk);
  endtask
endmodule

// >>> verif/tb_ptcd_target.sv
// self-checking bench for the pci target decode block
`timescale 1ns/1ns
module tb_ptcd_target
  import ptcd_pkg::*;
();
  localparam logic [31:0] ID_VAL = 32'h0c0f_fee0; // arbitrary value
  typedef struct packed {
    logic [3:0]  cmd;
    logic [31:0] addr;
    logic        sel;
    logic [3:0]  be;
    logic [31:0] wd;
    logic        claim;
    logic [31:0] exp;
  } ptcd_row_s;

  logic        clk;
  logic        rst;
  logic        frame_n;
  logic        irdy_n;
  logic        idsel;
  logic [3:0]  cbe_n;
  logic [31:0] ad_in;
  logic [31:0] ad_out;
  logic        ad_oe_n;
  logic        devsel_n;
  logic        trdy_n;
  logic        stop_n;
  logic        ctl_oe_n;
  logic        eeprom_load_busy;
  ptcd_res_s   res_req;
  ptcd_res_s   last_req;
  logic [31:0] res_rdata;
  logic [31:0] rd;
  int          dv;
  int          tr;
  int          st;
  int          n;
  int          req_cnt = 0;
  int          num_errors = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [3:0]  rsv [7] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hd};
  int          wts [2] = '{0, 3};
  ptcd_row_s   rows [23] = '{
    '{CMD_CFG_RD, 32'h0000_0000, 1'h1, 4'hf, 32'h0, 1'h1, ID_VAL},
    '{CMD_CFG_RD, 32'h0000_0001, 1'h1, 4'hf, 32'h0, 1'h0, 32'h0},
    '{CMD_CFG_RD, 32'h0000_0000, 1'h0, 4'hf, 32'h0, 1'h0, 32'h0},
    '{CMD_CFG_RD, 32'hffff_f704, 1'h1, 4'hf, 32'h0, 1'h1, 32'h0080_0000},
    '{CMD_CFG_WR, 32'h0000_0004, 1'h1, 4'hf, 32'hffff_ffff, 1'h1, 32'h0},
    '{CMD_CFG_RD, 32'h0000_0004, 1'h1, 4'hf, 32'h0, 1'h1, 32'h0080_0003},
    '{CMD_CFG_WR, 32'h0000_000c, 1'h1, 4'h1, 32'haabb_ccdd, 1'h1, 32'h0},
    '{CMD_CFG_WR, 32'h0000_000c, 1'h1, 4'hc, 32'h1122_3344, 1'h1, 32'h0},
    '{CMD_CFG_RD, 32'h0000_000c, 1'h1, 4'h3, 32'h0, 1'h1, 32'h1122_00dd},
    '{CMD_CFG_WR, 32'h0000_0010, 1'h1, 4'hf, 32'h0000_1000, 1'h1, 32'h0},
    '{CMD_CFG_RD, 32'h0000_0010, 1'h1, 4'hf, 32'h0, 1'h1, 32'h0000_1001},
    '{CMD_CFG_WR, 32'h0000_0014, 1'h1, 4'hf, 32'h8000_0000, 1'h1, 32'h0},
    '{CMD_CFG_WR, 32'h0000_0030, 1'h1, 4'hf, 32'h9000_0001, 1'h1, 32'h0},
    '{CMD_CFG_WR, 32'h0000_0080, 1'h1, 4'hf, 32'hffff_ffff, 1'h1, 32'h0},
    '{CMD_CFG_RD, 32'h0000_0080, 1'h1, 4'hf, 32'h0, 1'h1, 32'h0},
    '{CMD_IO_RD, 32'h0000_1004, 1'h0, 4'hf, 32'h0, 1'h1, 32'h5a50_0004},
    '{CMD_IO_WR, 32'h0000_101c, 1'h0, 4'hf, 32'h55, 1'h1, 32'h0},
    '{CMD_IO_RD, 32'h0000_1020, 1'h0, 4'hf, 32'h0, 1'h0, 32'h0},
    '{CMD_MEM_RD, 32'h8000_0008, 1'h0, 4'hf, 32'h0, 1'h1, 32'h5a50_0008},
    '{CMD_MEM_RDM, 32'h8000_0010, 1'h0, 4'hf, 32'h0, 1'h1, 32'h5a50_0010},
    '{CMD_MEM_RDL, 32'h8000_0018, 1'h0, 4'hf, 32'h0, 1'h1, 32'h5a50_0018},
    '{CMD_MEM_WRI, 32'h8000_0004, 1'h0, 4'hf, 32'h66, 1'h1, 32'h0},
    '{CMD_MEM_RD, 32'h9001_2344, 1'h0, 4'hf, 32'h0, 1'h1, 32'h5a51_2344}
  };

  // register groups answer with a tag and the offset they were given
  assign res_rdata = {12'h5a5, res_req.off};

  ptcd_target #(.ID_WORD(ID_VAL)) u_ptcd_target (
    .clk(clk), .rst(rst), .frame_n(frame_n), .irdy_n(irdy_n), .idsel(idsel),
    .cbe_n(cbe_n), .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
    .devsel_n(devsel_n), .trdy_n(trdy_n), .stop_n(stop_n), .ctl_oe_n(ctl_oe_n),
    .eeprom_load_busy(eeprom_load_busy), .res_req(res_req), .res_rdata(res_rdata)
  );

  ptcd_host_model u_ptcd_host_model (
    .clk(clk), .frame_n(frame_n), .irdy_n(irdy_n), .idsel(idsel), .cbe_n(cbe_n),
    .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .devsel_n(devsel_n),
    .trdy_n(trdy_n), .stop_n(stop_n), .ctl_oe_n(ctl_oe_n)
  );

  // clock, 40 ns period
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // request capture and hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (res_req.valid) begin
      last_req <= res_req;
      req_cnt  <= req_cnt + 1;
    end
    if (cycles == 3000) begin
      num_errors++;
      complete_run;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input ptcd_row_s r, input logic burst, input int wt, input logic fbb);
    u_ptcd_host_model.xfer(r.cmd, r.addr, r.sel, r.be, r.wd, burst, wt, fbb, rd, dv, tr, st);
  endtask

  task automatic complete_run;
    if (num_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rst = 1'h1;
    eeprom_load_busy = 1'h0;
    repeat (3) @(negedge clk);
    rst = 1'h0;
    check({27'h0, devsel_n, trdy_n, stop_n, ctl_oe_n, ad_oe_n}, 32'h1f);
    check({31'h0, res_req.valid}, 32'h0);
    foreach (rows[i]) begin
      bus(rows[i], 1'h0, 0, 1'h0);
      if (rows[i].claim) begin
        check(32'(dv), 32'h2);
        check(32'(tr), 32'h3);
        if (!rows[i].cmd[0]) check(rd, rows[i].exp);
      end else begin
        check(32'(dv), 32'h0);
      end
    end
    foreach (rsv[i]) begin
      bus(ptcd_row_s'{rsv[i], 32'h8000_0000, 1'h1, 4'hf, 32'h0, 1'h0, 32'h0}, 1'h0, 0, 1'h0);
      check(32'(dv), 32'h0);
    end
    // io write request content
    n = req_cnt;
    bus(ptcd_row_s'{CMD_IO_WR, 32'h1014, 1'h0, 4'h3, 32'h1234_abcd, 1'h1, 32'h0}, 1'h0, 0, 1'h0);
    check(32'(req_cnt - n), 32'h1);
    check({6'h0, last_req.write, last_req.rom, last_req.be, last_req.off},
          {6'h0, 1'h1, 1'h0, 4'h3, 20'h14});
    check(last_req.wdata, 32'h1234_abcd);
    // burst disconnect, host ready at once and late
    foreach (wts[i]) begin
      bus(ptcd_row_s'{CMD_CFG_RD, 32'hc, 1'h1, 4'hf, 32'h0, 1'h1, 32'h0}, 1'h1, wts[i], 1'h0);
      check(32'(tr), 32'h3);
      check(32'(st), (wts[i] == 0) ? 32'h3 : 32'(wts[i] + 2));
      check(rd, 32'h1122_00dd);
    end
    // retry while the eeprom load runs
    eeprom_load_busy = 1'h1;
    n = req_cnt;
    bus(ptcd_row_s'{CMD_CFG_WR, 32'hc, 1'h1, 4'hf, 32'hffff_ffff, 1'h1, 32'h0}, 1'h0, 0, 1'h0);
    check(32'(dv), 32'h2);
    check(32'(st), 32'h2);
    check(32'(tr), 32'h0);
    bus(ptcd_row_s'{CMD_IO_RD, 32'h1004, 1'h0, 4'hf, 32'h0, 1'h1, 32'h0}, 1'h0, 0, 1'h0);
    check(32'(st), 32'h2);
    check(32'(req_cnt - n), 32'h0);
    eeprom_load_busy = 1'h0;
    bus(ptcd_row_s'{CMD_CFG_RD, 32'hc, 1'h1, 4'hf, 32'h0, 1'h1, 32'h0}, 1'h0, 0, 1'h0);
    check(rd, 32'h1122_00dd);
    // address straight after a foreign data phase
    bus(ptcd_row_s'{CMD_CFG_RD, 32'h0, 1'h1, 4'hf, 32'h0, 1'h1, 32'h0}, 1'h0, 0, 1'h1);
    check(32'(dv), 32'h2);
    check(rd, ID_VAL);
    // second reset clears the enables
    rst = 1'h1;
    repeat (3) @(negedge clk);
    rst = 1'h0;
    check({27'h0, devsel_n, trdy_n, stop_n, ctl_oe_n, ad_oe_n}, 32'h1f);
    check(ad_out, 32'h0);
    bus(ptcd_row_s'{CMD_CFG_RD, 32'h4, 1'h1, 4'hf, 32'h0, 1'h1, 32'h0}, 1'h0, 0, 1'h0);
    check(rd, 32'h0080_0000);
    bus(ptcd_row_s'{CMD_IO_RD, 32'h1004, 1'h0, 4'hf, 32'h0, 1'h1, 32'h0}, 1'h0, 0, 1'h0);
    check(32'(dv), 32'h0);
    complete_run;
  end
endmodule
